// [seq_pkg.sv]
// Package of constants for the rail enable sequencer
package seq_pkg;
   // Power-up ordering options
   typedef enum logic [1:0] {
      ORDER_ALL_AT_ONCE,
      ORDER_BUCK_ONE_FIRST,
      ORDER_BUCK_TWO_FIRST
   } order_t;

   localparam order_t DELIVERED_ORDER = ORDER_BUCK_ONE_FIRST;

   // Discharge hold after supply loss
   localparam int unsigned CLOCK_HZ        = 50_000_000;
   localparam int unsigned DISCHARGE_MS    = 200;
   localparam int unsigned DISCHARGE_CYCLES = (CLOCK_HZ / 1000) * DISCHARGE_MS;

   // LED current code: 0 = 7.5 mA, steps of 0.5 mA to 15 mA, then 1 mA to 30 mA
   localparam int unsigned LED_CODE_W      = 5;
   localparam logic [4:0]  LED_CODE_7P5MA  = 5'h00;
   localparam logic [4:0]  LED_CODE_MAX    = 5'h1e;

   // Rail index positions in the enable and power-good vectors
   localparam int unsigned RAIL_BUCK_ONE   = 0;
   localparam int unsigned RAIL_LINREG_ONE = 1;
   localparam int unsigned RAIL_BUCK_TWO   = 2;
   localparam int unsigned RAIL_LINREG_TWO = 3;
   localparam int unsigned RAIL_COUNT      = 4;
endpackage : seq_pkg

// [level_sync.sv]
// Two-flop synchroniser for a vector of levels
`timescale 1ns/100ps
module level_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] async_in,
   output      logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : level_sync

// [rail_enable_sequencer.sv]
// Rail enable sequencer: supply lockout, ordered rail start, discharge, thermal, LED gate
`timescale 1ns/100ps
module rail_enable_sequencer #(
   parameter seq_pkg::order_t                     ORDER            = seq_pkg::DELIVERED_ORDER,
   parameter int unsigned                         DISCHARGE_CYCLES = seq_pkg::DISCHARGE_CYCLES,
   parameter logic [seq_pkg::LED_CODE_W-1:0]      LED_CODE         = seq_pkg::LED_CODE_7P5MA
) (
   input  wire logic                              clock,
   input  wire logic                              srst,
   input  wire logic                              supply_ok,
   input  wire logic                              supply_present,
   input  wire logic                              over_temp,
   input  wire logic [seq_pkg::RAIL_COUNT-1:0]    rail_power_good,
   input  wire logic                              led_dim,
   output logic                                   buck_rail_one_en,
   output logic                                   buck_rail_two_en,
   output logic                                   linreg_rail_one_en,
   output logic                                   linreg_rail_two_en,
   output logic                                   discharge_en,
   output logic                                   core_active,
   output logic                                   led_sink_en,
   output logic                                   led_current_sink_output_oe,
   output logic [seq_pkg::LED_CODE_W-1:0]         led_current_code
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (DISCHARGE_CYCLES < 1) begin : g_bad_dis
      $error("Discharge hold must be at least one cycle");
   end
   if (LED_CODE > seq_pkg::LED_CODE_MAX) begin : g_bad_led
      $error("LED current code out of range");
   end

   // ------------------------------------------------------------
   // Synchronisers
   // ------------------------------------------------------------
   localparam int unsigned SYNC_W = seq_pkg::RAIL_COUNT + 4;

   logic [SYNC_W-1:0]              sync_vec;
   logic                           supply_ok_s;
   logic                           supply_present_s;
   logic                           over_temp_s;
   logic                           led_dim_s;
   logic [seq_pkg::RAIL_COUNT-1:0] pgood_s;

   level_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .clock    (clock),
      .srst     (srst),
      .async_in ({led_dim, over_temp, supply_present, supply_ok, rail_power_good}),
      .sync_out (sync_vec)
   );

   assign pgood_s          = sync_vec[seq_pkg::RAIL_COUNT-1:0];
   assign supply_ok_s      = sync_vec[seq_pkg::RAIL_COUNT];
   assign supply_present_s = sync_vec[seq_pkg::RAIL_COUNT+1];
   assign over_temp_s      = sync_vec[seq_pkg::RAIL_COUNT+2];
   assign led_dim_s        = sync_vec[seq_pkg::RAIL_COUNT+3];

   // ------------------------------------------------------------
   // Sequencer state machine
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_SHUTDOWN,
      ST_STEP_ONE,
      ST_STEP_TWO,
      ST_STEP_THREE,
      ST_STEP_FOUR,
      ST_RUN
   } seq_state_t;

   seq_state_t state_q;
   seq_state_t state_d;
   logic       run_ok;

   // Supply good and no thermal fault is the only start condition
   assign run_ok = supply_ok_s && !over_temp_s;

   // Rail order per step, fixed by parameter only
   function automatic int unsigned step_rail(input int unsigned step);
      int unsigned r;
      r = seq_pkg::RAIL_BUCK_ONE;
      if (ORDER == seq_pkg::ORDER_BUCK_TWO_FIRST) begin
         case (step)
            0: r = seq_pkg::RAIL_BUCK_TWO;
            1: r = seq_pkg::RAIL_LINREG_TWO;
            2: r = seq_pkg::RAIL_BUCK_ONE;
            default: r = seq_pkg::RAIL_LINREG_ONE;
         endcase
      end else begin
         case (step)
            0: r = seq_pkg::RAIL_BUCK_ONE;
            1: r = seq_pkg::RAIL_LINREG_ONE;
            2: r = seq_pkg::RAIL_BUCK_TWO;
            default: r = seq_pkg::RAIL_LINREG_TWO;
         endcase
      end
      return r;
   endfunction : step_rail

   always_comb begin
      state_d = state_q;
      if (!run_ok) begin
         state_d = ST_SHUTDOWN;
      end else begin
         case (state_q)
            ST_SHUTDOWN: begin
               if (ORDER == seq_pkg::ORDER_ALL_AT_ONCE) begin
                  state_d = ST_RUN;
               end else begin
                  state_d = ST_STEP_ONE;
               end
            end
            ST_STEP_ONE: begin
               if (pgood_s[step_rail(0)]) begin
                  state_d = ST_STEP_TWO;
               end
            end
            ST_STEP_TWO: begin
               if (pgood_s[step_rail(1)]) begin
                  state_d = ST_STEP_THREE;
               end
            end
            ST_STEP_THREE: begin
               if (pgood_s[step_rail(2)]) begin
                  state_d = ST_STEP_FOUR;
               end
            end
            ST_STEP_FOUR: begin
               if (pgood_s[step_rail(3)]) begin
                  state_d = ST_RUN;
               end
            end
            default: begin
               state_d = ST_RUN;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         state_q <= ST_SHUTDOWN;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // Rail enables
   // ------------------------------------------------------------
   logic [seq_pkg::RAIL_COUNT-1:0] rail_en_d;
   int unsigned                    steps_on;

   always_comb begin
      rail_en_d = '0;
      steps_on  = 0;
      case (state_d)
         ST_STEP_ONE:   steps_on = 1;
         ST_STEP_TWO:   steps_on = 2;
         ST_STEP_THREE: steps_on = 3;
         ST_STEP_FOUR:  steps_on = 4;
         ST_RUN:        steps_on = 4;
         default:       steps_on = 0;
      endcase
      for (int unsigned i = 0; i < seq_pkg::RAIL_COUNT; i++) begin
         if (i < steps_on) begin
            rail_en_d[step_rail(i)] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         buck_rail_one_en   <= 1'b0;
         linreg_rail_one_en <= 1'b0;
         buck_rail_two_en   <= 1'b0;
         linreg_rail_two_en <= 1'b0;
         core_active        <= 1'b0;
      end else begin
         buck_rail_one_en   <= rail_en_d[seq_pkg::RAIL_BUCK_ONE];
         linreg_rail_one_en <= rail_en_d[seq_pkg::RAIL_LINREG_ONE];
         buck_rail_two_en   <= rail_en_d[seq_pkg::RAIL_BUCK_TWO];
         linreg_rail_two_en <= rail_en_d[seq_pkg::RAIL_LINREG_TWO];
         // Whole core off whenever no rail is enabled
         core_active        <= |rail_en_d;
      end
   end

   // ------------------------------------------------------------
   // Output discharge
   // ------------------------------------------------------------
   // Counter keeps the caps draining after the supply is gone; a tiny
   // reserve supply is assumed to keep this logic alive meanwhile.
   localparam int unsigned DIS_W = $clog2(DISCHARGE_CYCLES + 1);

   logic [DIS_W-1:0] dis_count_q;
   logic             supply_ok_prev_q;

   always_ff @(posedge clock) begin
      if (srst) begin
         supply_ok_prev_q <= 1'b0;
      end else begin
         supply_ok_prev_q <= supply_ok_s;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         dis_count_q <= '0;
      end else if (supply_ok_s) begin
         dis_count_q <= '0;
      end else if (supply_ok_prev_q) begin
         dis_count_q <= DIS_W'(DISCHARGE_CYCLES);
      end else if (dis_count_q != '0) begin
         dis_count_q <= dis_count_q - 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         discharge_en <= 1'b0;
      end else if (supply_ok_s) begin
         discharge_en <= 1'b0;
      end else if (supply_ok_prev_q) begin
         discharge_en <= 1'b1;
      end else begin
         // Ramp-up window and hold after loss
         discharge_en <= supply_present_s || (dis_count_q > DIS_W'(1));
      end
   end

   // ------------------------------------------------------------
   // LED current sink
   // ------------------------------------------------------------
   // dimming input assumed at most 50kHz, so two-flop delay is negligible
   always_ff @(posedge clock) begin
      if (srst) begin
         led_sink_en                <= 1'b0;
         led_current_sink_output_oe <= 1'b0;
         led_current_code           <= seq_pkg::LED_CODE_7P5MA;
      end else begin
         led_sink_en                <= led_dim_s && !over_temp_s;
         led_current_sink_output_oe <= led_dim_s && !over_temp_s;
         led_current_code           <= LED_CODE;
      end
   end
endmodule : rail_enable_sequencer

// [rail_seq_chk.sv]
// Port-level assertions for the rail enable sequencer
`timescale 1ns/100ps
module rail_seq_chk #(
   parameter logic [4:0] LED_CODE = 5'h00
) (
   input wire logic       clock,
   input wire logic       srst,
   input wire logic       supply_ok,
   input wire logic       supply_present,
   input wire logic       over_temp,
   input wire logic [3:0] rail_power_good,
   input wire logic       led_dim,
   input wire logic       buck_rail_one_en,
   input wire logic       buck_rail_two_en,
   input wire logic       linreg_rail_one_en,
   input wire logic       linreg_rail_two_en,
   input wire logic       discharge_en,
   input wire logic       core_active,
   input wire logic       led_sink_en,
   input wire logic       led_current_sink_output_oe,
   input wire logic [4:0] led_current_code
);
   wire logic [3:0] rails = {linreg_rail_two_en, buck_rail_two_en,
                             linreg_rail_one_en, buck_rail_one_en};
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // Inputs are steady for the full sync latency, else the answer is undefined
   property p_start;
      $rose(supply_ok) && !over_temp ##1 (supply_ok && !over_temp)[*2]
         |-> ##1 rails == 4'h1 && core_active && !discharge_en; endproperty
   a_start: assert property (p_start) else $error("first rail not alone");
   property p_loss;
      $fell(supply_ok) |-> ##3 rails == 4'h0 && !core_active && discharge_en; endproperty
   a_loss: assert property (p_loss) else $error("supply loss not handled");
   property p_hot;
      $rose(over_temp) |-> ##3 rails == 4'h0 && !led_sink_en && !led_current_sink_output_oe;
   endproperty
   a_hot: assert property (p_hot) else $error("hot shutdown missed");
   property p_off; (!supply_ok)[*4] |-> rails == 4'h0 && !core_active; endproperty
   a_off: assert property (p_off) else $error("rail on without supply");
   property p_core; core_active == (rails != 4'h0); endproperty
   a_core: assert property (p_core) else $error("core state wrong");
   property p_step;
      $rose(buck_rail_two_en) |-> linreg_rail_one_en && $past(rail_power_good[1], 3);
   endproperty
   a_step: assert property (p_step) else $error("step out of order");
   property p_led;
      $rose(led_dim) && !over_temp ##1 (led_dim && !over_temp)[*2] |-> ##1 led_sink_en
         && led_current_sink_output_oe && led_current_code == LED_CODE; endproperty
   a_led: assert property (p_led) else $error("sink not on");
   property p_dark;
      $fell(led_dim) |-> ##3 !led_sink_en && !led_current_sink_output_oe; endproperty
   a_dark: assert property (p_dark) else $error("sink not off");
   property p_hold;
      $fell(supply_ok) && !supply_present |-> ##3 discharge_en[*8] ##[1:30] !discharge_en;
   endproperty
   a_hold: assert property (p_hold) else $error("discharge hold wrong");
   property p_cool;
      $fell(over_temp) && supply_ok ##1 (supply_ok && !over_temp)[*2] |-> ##1 rails == 4'h1;
   endproperty
   a_cool: assert property (p_cool) else $error("no restart");
   c_all_on: cover property (rails == 4'hf);
   c_hold_end: cover property ($fell(discharge_en));
   c_led_on: cover property (led_sink_en);
endmodule : rail_seq_chk

bind rail_enable_sequencer rail_seq_chk #(.LED_CODE(LED_CODE)) i_chk (
   .clock(clock), .srst(srst), .supply_ok(supply_ok), .supply_present(supply_present),
   .over_temp(over_temp), .rail_power_good(rail_power_good), .led_dim(led_dim),
   .buck_rail_one_en(buck_rail_one_en), .buck_rail_two_en(buck_rail_two_en),
   .linreg_rail_one_en(linreg_rail_one_en), .linreg_rail_two_en(linreg_rail_two_en),
   .discharge_en(discharge_en), .core_active(core_active), .led_sink_en(led_sink_en),
   .led_current_sink_output_oe(led_current_sink_output_oe),
   .led_current_code(led_current_code));

// [rail_analog_model.sv]
// Behavioural model of the regulators' power-good comparators
`timescale 1ns/100ps
module rail_analog_model #(
   parameter int unsigned RISE = 4
) (
   input  wire logic       clock,
   input  wire logic       slow,
   input  wire logic [3:0] rail_en,
   output logic      [3:0] rail_power_good
);
   int unsigned age_q [4];
   // Good drops with the enable; a slow rail takes four times as long
   always_ff @(posedge clock) begin
      for (int i = 0; i < 4; i++) begin
         age_q[i] <= rail_en[i] ? age_q[i] + 1 : 0;
         rail_power_good[i] <= rail_en[i] && age_q[i] >= (slow ? 4 * RISE : RISE);
      end
   end
endmodule : rail_analog_model

// [tb_rail_enable_sequencer.sv]
// Self-checking testbench for the rail enable sequencer
`timescale 1ns/100ps
module tb_rail_enable_sequencer;
   logic            clock = 1'b0;
   logic            srst = 1'b1;
   logic            supply_ok = 1'b0;
   logic            supply_present = 1'b0;
   logic            over_temp = 1'b0;
   logic            led_dim = 1'b0;
   logic            slow = 1'b0;
   logic [3:0]      pg;
   wire logic [3:0] rails;
   logic            discharge_en;
   logic            core_active;
   logic            led_sink_en;
   logic            sink_oe;
   logic [4:0]      led_current_code;
   int              n_errors = 0;
   int              checks_done = 0;

   always #10 clock = ~clock;

   rail_enable_sequencer #(.DISCHARGE_CYCLES(20)) i_dut (
      .clock(clock), .srst(srst), .supply_ok(supply_ok), .supply_present(supply_present),
      .over_temp(over_temp), .rail_power_good(pg), .led_dim(led_dim),
      .buck_rail_one_en(rails[0]), .linreg_rail_one_en(rails[1]),
      .buck_rail_two_en(rails[2]), .linreg_rail_two_en(rails[3]),
      .discharge_en(discharge_en), .core_active(core_active), .led_sink_en(led_sink_en),
      .led_current_sink_output_oe(sink_oe), .led_current_code(led_current_code));
   rail_analog_model i_rails (.clock(clock), .slow(slow), .rail_en(rails), .rail_power_good(pg));

   task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic ticks(input int n);
      repeat (n) @(negedge clock);
   endtask : ticks

   task automatic test_done();
      if (n_errors == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done

   // Rails must come on in index order, one more per step
   task automatic walk_up();
      for (int k = 0; k < 4; k++) begin
         for (int t = 0; t < 200 && rails[k] !== 1'b1; t++) ticks(1);
         check("rails", 5'(rails), 5'((5'h2 << k) - 5'h1));
      end
   endtask : walk_up

   task automatic t_ramp_up();
      supply_present = 1'b1;
      ticks(4);
      check("discharge", 5'(discharge_en), 5'h1);
      check("core", 5'(core_active), 5'h0);
      supply_ok = 1'b1;
      ticks(3);
      check("discharge", 5'(discharge_en), 5'h0);
      walk_up();
   endtask : t_ramp_up

   task automatic t_led();
      for (int p = 0; p < 2; p++) begin
         led_dim = 1'b1;
         ticks(50);
         check("sink", 5'({led_sink_en, sink_oe}), 5'h3);
         check("code", led_current_code, 5'h00);
         led_dim = 1'b0;
         ticks(950);
         check("sink", 5'({led_sink_en, sink_oe}), 5'h0);
      end
   endtask : t_led

   task automatic t_hot();
      led_dim = 1'b1;
      over_temp = 1'b1;
      ticks(3);
      check("rails", 5'(rails), 5'h0);
      check("sink", 5'({led_sink_en, sink_oe}), 5'h0);
      ticks(10);
      over_temp = 1'b0;
      ticks(3);
      walk_up();
      led_dim = 1'b0;
   endtask : t_hot

   // Slow rails keep the sequence mid-way when the supply goes
   task automatic t_abort();
      slow = 1'b1;
      supply_ok = 1'b0;
      ticks(10);
      supply_ok = 1'b1;
      for (int t = 0; t < 200 && rails[1] !== 1'b1; t++) ticks(1);
      check("rails", 5'(rails), 5'h3);
      supply_ok = 1'b0;
      supply_present = 1'b0;
      ticks(3);
      check("rails", 5'(rails), 5'h0);
      check("discharge", 5'(discharge_en), 5'h1);
      ticks(10);
      check("discharge", 5'(discharge_en), 5'h1);
      ticks(40);
      check("discharge", 5'(discharge_en), 5'h0);
   endtask : t_abort

   initial begin
      ticks(2);
      srst = 1'b0;
      t_ramp_up();
      t_led();
      t_hot();
      t_abort();
      test_done();
   end

   initial begin
      repeat (20000) @(posedge clock);
      n_errors++;
      test_done();
   end
endmodule : tb_rail_enable_sequencer
